// ### rtl/sc_pkg.sv
// constants shared by the correction datapath and its helpers
package sc_pkg;

  // register indexes on the plain register port
  localparam logic [3:0] REG_GAIN_B   = 4'h0;
  localparam logic [3:0] REG_OFFSET_B = 4'h1;
  localparam logic [3:0] REG_GAIN_T   = 4'h2;
  localparam logic [3:0] REG_OFFSET_T = 4'h3;
  localparam logic [3:0] REG_TCO      = 4'h4;
  localparam logic [3:0] REG_TCG      = 4'h5;
  localparam logic [3:0] REG_DRIFT_SIGN_SCALE_CFG   = 4'h6;
  localparam logic [3:0] REG_SOT      = 4'h7;
  localparam logic [3:0] REG_SOT_SEL  = 4'h8;
  localparam logic [3:0] REG_TREF     = 4'h9;
  localparam logic [3:0] REG_BR_OUT   = 4'ha;
  localparam logic [3:0] REG_T_OUT    = 4'hb;
  localparam logic [3:0] REG_STATUS   = 4'hc;

  // values after reset
  localparam logic [14:0] RST_GAIN_B  = 15'h0800;  // unity bridge gain
  localparam logic [7:0]  RST_GAIN_T  = 8'h80;     // unity temperature gain
  localparam logic [1:0]  RST_SOT_SEL = 2'h1;      // second order on gain drift

  // field positions
  localparam int GAIN_B_X8_BIT = 14;
  localparam int CFG_TCO_SIGN  = 0;
  localparam int CFG_TCO_X8    = 1;
  localparam int CFG_TCG_SIGN  = 2;
  localparam int SOT_SIGN_BIT  = 7;

  // fraction bits of the fixed point coefficients
  localparam int GAIN_B_FRAC = 11;
  localparam int GAIN_T_FRAC = 7;

  // result range
  localparam logic [13:0] RESULT_MAX = 14'h3fff;

  // cycles from sample strobe to result strobe
  localparam int LATENCY = 4;

  // second order target selector codes
  typedef enum logic [1:0] {
    SOT_BRIDGE = 2'h0,
    SOT_TCG    = 2'h1,
    SOT_TCO    = 2'h2,
    SOT_BAD    = 2'h3
  } sot_target_e;

endpackage : sc_pkg

// ### rtl/coeff_decode.sv
// decodes stored coefficient codes into signed working values
`timescale 1ns/1ps
module coeff_decode (
  input  wire logic [14:0]       gain_b_raw,
  input  wire logic [2:0]        cfg,
  input  wire logic [7:0]        tco_mag,
  input  wire logic [7:0]        tcg_mag,
  input  wire logic [7:0]        sot_raw,
  input  wire logic [1:0]        sel,
  output logic        [16:0]     gain_b_eff,
  output logic signed [8:0]      tco_s,
  output logic signed [8:0]      tcg_s,
  output logic signed [7:0]      sot_s,
  output logic                   tco_x8,
  output logic                   sot_bridge,
  output logic                   sot_tcg,
  output logic                   sot_tco,
  output logic                   sel_bad
);

  // top bit scales the fourteen bit fraction by eight
  assign gain_b_eff = gain_b_raw[sc_pkg::GAIN_B_X8_BIT] ?
                      {gain_b_raw[13:0], 3'h0} : {3'h0, gain_b_raw[13:0]}; // RULE3 RULE4

  // drift magnitudes carry their signs in the config bits
  assign tco_s = cfg[sc_pkg::CFG_TCO_SIGN] ? -$signed({1'b0, tco_mag})
                                           : $signed({1'b0, tco_mag}); // RULE8
  assign tcg_s = cfg[sc_pkg::CFG_TCG_SIGN] ? -$signed({1'b0, tcg_mag})
                                           : $signed({1'b0, tcg_mag}); // RULE9
  assign tco_x8 = cfg[sc_pkg::CFG_TCO_X8]; // RULE8

  // second order term is sign and seven bit magnitude
  assign sot_s = sot_raw[sc_pkg::SOT_SIGN_BIT] ? -$signed({1'b0, sot_raw[6:0]})
                                               : $signed({1'b0, sot_raw[6:0]}); // RULE12

  // at most one target; the prohibited code applies it nowhere
  assign sot_bridge = (sel == sc_pkg::SOT_BRIDGE); // RULE10 RULE11
  assign sot_tcg    = (sel == sc_pkg::SOT_TCG);    // RULE11
  assign sot_tco    = (sel == sc_pkg::SOT_TCO);    // RULE11
  assign sel_bad    = (sel == sc_pkg::SOT_BAD);    // RULE11

endmodule : coeff_decode

// ### rtl/sat14.sv
// clamps a signed value into the unsigned fourteen bit result range
`timescale 1ns/1ps
module sat14 #(
  parameter int W = 16
) (
  input  wire logic signed [W-1:0] value,
  output logic [13:0]              clamped,
  output logic                     hit
);

  // upper bound widened to the input width
  localparam logic signed [W-1:0] HI = $signed({{(W-14){1'b0}}, sc_pkg::RESULT_MAX});

  // clamp rather than wrap at either end
  always_comb begin
    clamped = value[13:0];
    hit     = 1'b0;
    if (value < 0) begin
      clamped = 14'h0000;
      hit     = 1'b1;
    end else if (value > HI) begin
      clamped = sc_pkg::RESULT_MAX;
      hit     = 1'b1;
    end
  end

endmodule : sat14

// ### rtl/sensor_correction_coeff_decode.sv
// bridge and temperature correction datapath with coefficient registers
//
// What this block does
// RULE1: raw bridge is unsigned fourteen bits, step one
// RULE2: raw temperature is unsigned, step four counts
// RULE3: bridge gain bit 14 multiplies by eight
// RULE4: bridge gain low bits are unsigned 3.11
// RULE5: bridge offset: sign bit weighs -16384
// RULE6: temperature gain is unsigned 1.7 fixed point
// RULE7: temperature offset is eight bit two's complement
// RULE8: offset drift: magnitude, sign cfg0, x8 cfg1
// RULE9: gain drift: magnitude, sign cfg2, never scaled
// RULE10: second order term corrects exactly one target; selector 11 applies it to none
// RULE11: selector 00 bridge, 01 gain, 10 offset
// RULE12: second order term is sign and magnitude
// RULE13: x8 flag also scales second order offset share
// RULE14: bridge nonlinearity saturates instead of wrapping
// RULE15: seven bit reference temperature is drift origin
// RULE16: host computes and loads every coefficient
// RULE17: results saturate to 0 and 16383
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module sensor_correction_coeff_decode (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] write_data,
  input  wire logic        write_strobe,
  input  wire logic        read_strobe,
  output logic      [15:0] read_data,
  input  wire logic        sample_valid,
  input  wire logic [13:0] raw_bridge_result,
  input  wire logic [13:0] internal_temp_sense_raw,
  output logic      [13:0] bridge_out,
  output logic      [13:0] temp_out,
  output logic             out_valid,
  output logic             sel_fault
);

  // coefficient store, loaded by software
  logic [14:0] gain_b_q;                    // bridge gain code
  logic [14:0] offset_b_q;                  // two's complement, sign bit weighs -16384
  logic [7:0]  gain_t_q;                    // temperature gain
  logic [7:0]  offset_t_q;                  // temperature offset
  logic [7:0]  tco_q;                       // offset drift magnitude
  logic [7:0]  tcg_q;                       // gain drift magnitude
  logic [2:0]  drift_sign_scale_cfg_q;      // signs and scale
  logic [7:0]  second_order_coeff_q;        // second order term
  logic [1:0]  second_order_target_sel_q;   // where it applies
  logic [6:0]  cal_low_temp_ref_q;          // drift origin

  // decoded coefficients
  logic [16:0]        gain_b_eff;
  logic signed [8:0]  tco_s;
  logic signed [8:0]  tcg_s;
  logic signed [7:0]  sot_s;
  logic               tco_x8;
  logic               sot_bridge;
  logic               sot_tcg;
  logic               sot_tco;
  logic               sel_bad;

  // pipeline state
  logic               v0_q;                 // stage flags
  logic               v1_q;
  logic               v2_q;
  logic [13:0]        rb_q;                 // captured bridge
  logic [13:0]        rt_q;                 // captured temperature
  logic signed [21:0] b1_q;                 // gained bridge plus offset
  logic signed [23:0] tco_dt_q;             // offset drift times dt
  logic signed [20:0] tcg_dt_q;             // gain drift times dt
  logic signed [16:0] t1_q;                 // corrected temperature
  logic [13:0]        b2c_q;                // drift corrected bridge
  logic [13:0]        t2_q;                 // clamped temperature
  logic               b2_hit_q;             // clamp hit in stage two
  logic               t_hit_q;
  logic               bridge_sat_q;         // status flags
  logic               temp_sat_q;

  // coefficient decode
  wire signed [14:0] off_b_s = $signed(offset_b_q); // RULE5

  coeff_decode u_decode (
    .gain_b_raw (gain_b_q),
    .cfg        (drift_sign_scale_cfg_q),
    .tco_mag    (tco_q),
    .tcg_mag    (tcg_q),
    .sot_raw    (second_order_coeff_q),
    .sel        (second_order_target_sel_q),
    .gain_b_eff (gain_b_eff),
    .tco_s      (tco_s),
    .tcg_s      (tcg_s),
    .sot_s      (sot_s),
    .tco_x8     (tco_x8),
    .sot_bridge (sot_bridge),
    .sot_tcg    (sot_tcg),
    .sot_tco    (sot_tco),
    .sel_bad    (sel_bad)
  );

  // coefficient writes; unmapped or read only indexes are ignored
  always_ff @(posedge clock) begin
    if (reset) begin
      gain_b_q                  <= sc_pkg::RST_GAIN_B;
      offset_b_q                <= 15'h0000;
      gain_t_q                  <= sc_pkg::RST_GAIN_T;
      offset_t_q                <= 8'h00;
      tco_q                     <= 8'h00;
      tcg_q                     <= 8'h00;
      drift_sign_scale_cfg_q    <= 3'h0;
      second_order_coeff_q      <= 8'h00;
      second_order_target_sel_q <= sc_pkg::RST_SOT_SEL;
      cal_low_temp_ref_q        <= 7'h00;
    end else if (write_strobe) begin
      case (addr)
        sc_pkg::REG_GAIN_B:   gain_b_q                  <= write_data[14:0];
        sc_pkg::REG_OFFSET_B: offset_b_q                <= write_data[14:0];
        sc_pkg::REG_GAIN_T:   gain_t_q                  <= write_data[7:0];
        sc_pkg::REG_OFFSET_T: offset_t_q                <= write_data[7:0];
        sc_pkg::REG_TCO:      tco_q                     <= write_data[7:0];
        sc_pkg::REG_TCG:      tcg_q                     <= write_data[7:0];
        sc_pkg::REG_DRIFT_SIGN_SCALE_CFG:   drift_sign_scale_cfg_q    <= write_data[2:0];
        sc_pkg::REG_SOT:      second_order_coeff_q      <= write_data[7:0];
        sc_pkg::REG_SOT_SEL:  second_order_target_sel_q <= write_data[1:0];
        sc_pkg::REG_TREF:     cal_low_temp_ref_q        <= write_data[6:0];
        default: begin
        end
      endcase
    end
  end

  // read data stands for one cycle only, zero otherwise
  always_ff @(posedge clock) begin
    if (reset) begin
      read_data <= 16'h0000;
    end else if (read_strobe) begin
      case (addr)
        sc_pkg::REG_GAIN_B:   read_data <= {1'b0, gain_b_q};
        sc_pkg::REG_OFFSET_B: read_data <= {1'b0, offset_b_q};
        sc_pkg::REG_GAIN_T:   read_data <= {8'h00, gain_t_q};
        sc_pkg::REG_OFFSET_T: read_data <= {8'h00, offset_t_q};
        sc_pkg::REG_TCO:      read_data <= {8'h00, tco_q};
        sc_pkg::REG_TCG:      read_data <= {8'h00, tcg_q};
        sc_pkg::REG_DRIFT_SIGN_SCALE_CFG:   read_data <= {13'h0000, drift_sign_scale_cfg_q};
        sc_pkg::REG_SOT:      read_data <= {8'h00, second_order_coeff_q};
        sc_pkg::REG_SOT_SEL:  read_data <= {14'h0000, second_order_target_sel_q};
        sc_pkg::REG_TREF:     read_data <= {9'h000, cal_low_temp_ref_q};
        sc_pkg::REG_BR_OUT:   read_data <= {2'h0, bridge_out};
        sc_pkg::REG_T_OUT:    read_data <= {2'h0, temp_out};
        sc_pkg::REG_STATUS:   read_data <= {13'h0000, temp_sat_q, bridge_sat_q, sel_fault};
        default:              read_data <= 16'h0000;
      endcase
    end else begin
      read_data <= 16'h0000;
    end
  end

  // stage 0: capture raw readings; converter shares this clock
  always_ff @(posedge clock) begin
    if (reset) begin
      v0_q <= 1'b0;
      rb_q <= 14'h0000;
      rt_q <= 14'h0000;
    end else begin
      v0_q <= sample_valid;
      if (sample_valid) begin
        rb_q <= raw_bridge_result; // RULE1
        // the two lowest bits carry no information
        rt_q <= {internal_temp_sense_raw[13:2], 2'h0}; // RULE2
      end
    end
  end

  // stage 1 arithmetic: distance from the calibration temperature
  logic signed [7:0]  dt_w;
  logic signed [15:0] sot_dt_w;
  logic signed [11:0] sot_t_w;
  logic signed [12:0] tco_tot_w;
  logic signed [12:0] tcg_tot_w;
  logic signed [15:0] tco_eff_w;
  logic signed [23:0] tco_dt_w;
  logic signed [20:0] tcg_dt_w;
  logic        [30:0] bg_w;
  logic signed [21:0] b1_w;
  logic        [21:0] tp_w;
  logic signed [16:0] t1_w;

  // seven bit origin compared against the top seven reading bits
  assign dt_w = $signed({1'b0, rt_q[13:7]}) - $signed({1'b0, cal_low_temp_ref_q}); // RULE15

  // second order share of a drift term grows with dt
  assign sot_dt_w  = sot_s * dt_w;
  assign sot_t_w   = sot_dt_w[15:4];
  assign tco_tot_w = 13'(tco_s) + 13'(sot_tco ? sot_t_w : 12'sh000); // RULE10
  assign tcg_tot_w = 13'(tcg_s) + 13'(sot_tcg ? sot_t_w : 12'sh000); // RULE9 RULE10

  // scaling sits after the sum so it covers the second order share
  assign tco_eff_w = tco_x8 ? (16'(tco_tot_w) <<< 3) : 16'(tco_tot_w); // RULE8 RULE13
  assign tco_dt_w  = tco_eff_w * dt_w;
  assign tcg_dt_w  = tcg_tot_w * dt_w;

  // bridge gain in 3.11 fixed point, offset sign extended
  assign bg_w = rb_q * gain_b_eff; // RULE4
  assign b1_w = $signed({2'h0, bg_w[30:sc_pkg::GAIN_B_FRAC]}) + 22'(off_b_s); // RULE5

  // temperature gain 1.7 fixed point plus signed offset
  assign tp_w = rt_q * gain_t_q; // RULE6
  assign t1_w = $signed({2'h0, tp_w[21:sc_pkg::GAIN_T_FRAC]}) + 17'($signed(offset_t_q)); // RULE7

  // stage 1 registers
  always_ff @(posedge clock) begin
    if (reset) begin
      v1_q     <= 1'b0;
      b1_q     <= 22'sh00_0000;
      tco_dt_q <= 24'sh00_0000;
      tcg_dt_q <= 21'sh00_0000;
      t1_q     <= 17'sh0_0000;
    end else begin
      v1_q <= v0_q;
      if (v0_q) begin
        b1_q     <= b1_w;
        tco_dt_q <= tco_dt_w;
        tcg_dt_q <= tcg_dt_w;
        t1_q     <= t1_w;
      end
    end
  end

  // stage 2 arithmetic: apply offset and gain drift
  logic signed [42:0] gterm_w;
  logic signed [27:0] b2_w;
  logic [13:0]        b2c_w;
  logic [13:0]        t2c_w;
  logic               b2_hit_w;
  logic               t_hit_w;

  assign gterm_w = b1_q * tcg_dt_q;
  assign b2_w = 28'(b1_q) + 28'(tco_dt_q >>> 4) + 28'($signed(gterm_w[42:16]));

  // clamping here keeps the squaring stage narrow
  sat14 #(.W(28)) u_sat_b2 (
    .value   (b2_w),
    .clamped (b2c_w),
    .hit     (b2_hit_w)
  );

  sat14 #(.W(17)) u_sat_t (
    .value   (t1_q),
    .clamped (t2c_w),
    .hit     (t_hit_w)
  );

  // stage 2 registers
  always_ff @(posedge clock) begin
    if (reset) begin
      v2_q     <= 1'b0;
      b2c_q    <= 14'h0000;
      t2_q     <= 14'h0000;
      b2_hit_q <= 1'b0;
      t_hit_q  <= 1'b0;
    end else begin
      v2_q <= v1_q;
      if (v1_q) begin
        b2c_q    <= b2c_w; // RULE17
        t2_q     <= t2c_w; // RULE17
        b2_hit_q <= b2_hit_w;
        t_hit_q  <= t_hit_w;
      end
    end
  end

  // stage 3 arithmetic: bridge nonlinearity from the square
  logic [27:0]        sq_w;
  logic signed [22:0] nl_w;
  logic signed [15:0] b3_w;
  logic [13:0]        b3c_w;
  logic               b3_hit_w;

  assign sq_w = b2c_q * b2c_q;
  assign nl_w = sot_s * $signed({1'b0, sq_w[27:14]});
  assign b3_w = $signed({2'h0, b2c_q}) + 16'(sot_bridge ? $signed(nl_w[22:9]) : 14'sh0000); // RULE10

  // a strong negative term must pin to zero, not wrap high
  sat14 #(.W(16)) u_sat_b3 (
    .value   (b3_w),
    .clamped (b3c_w),
    .hit     (b3_hit_w)
  ); // RULE14

  // result registers and status
  always_ff @(posedge clock) begin
    if (reset) begin
      out_valid    <= 1'b0;
      bridge_out   <= 14'h0000;
      temp_out     <= 14'h0000;
      bridge_sat_q <= 1'b0;
      temp_sat_q   <= 1'b0;
    end else begin
      out_valid <= v2_q;
      if (v2_q) begin
        bridge_out   <= b3c_w; // RULE14 RULE17
        temp_out     <= t2_q;
        bridge_sat_q <= b2_hit_q | b3_hit_w;
        temp_sat_q   <= t_hit_q;
      end
    end
  end

  // prohibited selector code shown to software as a level
  always_ff @(posedge clock) begin
    if (reset) begin
      sel_fault <= 1'b0;
    end else begin
      sel_fault <= sel_bad; // RULE11
    end
  end

  // checks
  AST_BRIDGE_CAPTURE: assert property (@(posedge clock) disable iff (reset)
    sample_valid |=> rb_q == $past(raw_bridge_result)) // RULE1
    else $error("raw bridge not captured");

  AST_TEMP_STEP: assert property (@(posedge clock) disable iff (reset)
    sample_valid |=> rt_q == {$past(internal_temp_sense_raw[13:2]), 2'h0}) // RULE2
    else $error("temperature step not four counts");

  AST_GAIN_X8: assert property (@(posedge clock) disable iff (reset)
    gain_b_q[14] |-> gain_b_eff == {gain_b_q[13:0], 3'h0}) // RULE3
    else $error("bridge gain scale bit ignored");

  AST_GAIN_PLAIN: assert property (@(posedge clock) disable iff (reset)
    v0_q && gain_b_q == 15'h0800 && offset_b_q == 15'h0000 |=> b1_q == 22'($past(rb_q))) // RULE4
    else $error("unity bridge gain not unity");

  AST_OFFSET_B: assert property (@(posedge clock) disable iff (reset)
    v0_q && gain_b_q == 15'h0000 |=> b1_q == 22'($signed($past(offset_b_q)))) // RULE5
    else $error("bridge offset sign wrong");

  AST_TEMP_GAIN: assert property (@(posedge clock) disable iff (reset)
    v0_q && gain_t_q == 8'h80 && offset_t_q == 8'h00 |=> t1_q == 17'($past(rt_q))) // RULE6
    else $error("unity temperature gain not unity");

  AST_TEMP_OFFSET: assert property (@(posedge clock) disable iff (reset)
    v0_q && gain_t_q == 8'h00 |=> t1_q == 17'($signed($past(offset_t_q)))) // RULE7
    else $error("temperature offset decode wrong");

  AST_TCO_SCALE: assert property (@(posedge clock) disable iff (reset)
    !sot_tco && tco_x8 |-> tco_eff_w == 16'(tco_s) * 16'sh0008) // RULE8
    else $error("offset drift scale wrong");

  AST_TCG_PLAIN: assert property (@(posedge clock) disable iff (reset)
    !sot_tcg && drift_sign_scale_cfg_q[1] |-> tcg_tot_w == 13'(tcg_s)) // RULE9
    else $error("gain drift scaled");

  AST_SEL_BAD: assert property (@(posedge clock) disable iff (reset)
    second_order_target_sel_q == 2'h3 |-> !(sot_bridge | sot_tcg | sot_tco) ##1 sel_fault) // RULE11
    else $error("prohibited selector applied");

  AST_SOT_X8: assert property (@(posedge clock) disable iff (reset)
    sot_tco && tco_x8 |-> tco_eff_w == (16'(tco_s) + 16'(sot_t_w)) * 16'sh0008) // RULE13
    else $error("second order offset share not scaled");

  AST_SAT_LO: assert property (@(posedge clock) disable iff (reset)
    v2_q && b3_w < 0 |=> bridge_out == 14'h0000 && bridge_sat_q) // RULE14
    else $error("bridge result wrapped below zero");

  AST_SAT_HI: assert property (@(posedge clock) disable iff (reset)
    v2_q && b3_w > 16'sh3fff |=> bridge_out == sc_pkg::RESULT_MAX && bridge_sat_q) // RULE17
    else $error("bridge result wrapped above full scale");

  AST_LATENCY: assert property (@(posedge clock) disable iff (reset)
    sample_valid |-> ##4 out_valid) // RULE17
    else $error("result strobe late");

endmodule : sensor_correction_coeff_decode

// ### bench/tb.sv
// self-checking testbench for the sensor correction datapath
`timescale 1ns/1ps
module tb;
  logic        clock;                    // 200 MHz core clock
  logic        reset;                    // synchronous, active high
  logic [3:0]  addr;                     // register index
  logic [15:0] write_data;               // register write value
  logic        write_strobe;             // one-cycle write pulse
  logic        read_strobe;              // one-cycle read pulse
  logic [15:0] read_data;                // read answer, one cycle late
  logic        sample_valid;             // raw readings strobe
  logic [13:0] raw_bridge_result;        // raw bridge reading
  logic [13:0] internal_temp_sense_raw;  // raw temperature reading
  logic [13:0] bridge_out;               // corrected bridge
  logic [13:0] temp_out;                 // corrected temperature
  logic        out_valid;                // result strobe
  logic        sel_fault;                // prohibited selector flag
  int          fails;                    // mismatches seen
  int          n_checks;                 // comparisons made
  logic [15:0] sh [0:9];                 // shadow of the coefficient registers
  logic [15:0] msk [0:9] = '{16'h7fff, 16'h7fff, 16'h00ff, 16'h00ff, 16'h00ff,
                             16'h00ff, 16'h0007, 16'h00ff, 16'h0003, 16'h007f};
  logic [3:0]  hist;                     // sample strobes of the last four edges
  logic [27:0] expq [$];                 // expected {bridge, temp} in flight
  logic [27:0] last;                     // newest expected result

  sensor_correction_coeff_decode dut (
    .clock(clock), .reset(reset), .addr(addr), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .sample_valid(sample_valid), .raw_bridge_result(raw_bridge_result),
    .internal_temp_sense_raw(internal_temp_sense_raw), .bridge_out(bridge_out),
    .temp_out(temp_out), .out_valid(out_valid), .sel_fault(sel_fault));

  // free running clock, 5 ns period
  always #2.5 clock = ~clock;

  // compare and count; case equality so unknowns never match
  task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // verdict and end of run
  task automatic print_verdict;
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // clamp to the fourteen bit result range
  function automatic logic [13:0] sat(input longint v);
    if (v < 0) return 14'h0000;
    if (v > 16383) return 14'h3fff;
    return v[13:0];
  endfunction : sat

  // expected {bridge, temp} from the shadow coefficients; all math in signed 64 bits
  function automatic logic [27:0] model(input logic [13:0] b, input logic [13:0] t);
    longint     dt, s, st, tco, tcg, b1, b2, ge;
    logic [1:0] sel;
    sel = sh[8][1:0];
    dt = longint'(t[13:7]) - longint'(sh[9][6:0]);
    s = sh[7][7] ? -longint'(sh[7][6:0]) : longint'(sh[7][6:0]);
    st = (s * dt) >>> 4;
    tco = sh[6][0] ? -longint'(sh[4][7:0]) : longint'(sh[4][7:0]);
    if (sel == 2'h2) tco = tco + st;
    if (sh[6][1]) tco = tco * 8;
    tcg = sh[6][2] ? -longint'(sh[5][7:0]) : longint'(sh[5][7:0]);
    if (sel == 2'h1) tcg = tcg + st;
    ge = sh[0][14] ? longint'(sh[0][13:0]) * 8 : longint'(sh[0][13:0]);
    b1 = ((longint'(b) * ge) >>> 11) + longint'($signed(sh[1][14:0]));
    b2 = sat(b1 + ((tco * dt) >>> 4) + ((b1 * tcg * dt) >>> 16));
    if (sel == 2'h0) b2 = b2 + ((s * ((b2 * b2) >>> 14)) >>> 9);
    return {sat(b2), sat(((longint'(t[13:2]) * 4 * longint'(sh[2][7:0])) >>> 7)
                         + longint'($signed(sh[3][7:0])))};
  endfunction : model

  // register write, shadow follows once the edge has taken it
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
    if (a < 4'ha) sh[a] = d & msk[a];
  endtask : wr

  // register read: answer in the next cycle only, then zero
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m);
    @(posedge clock);
    addr <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 chk(read_data & m, exp & m);
    @(posedge clock);
    #1 chk(read_data, 16'h0000);
  endtask : rd

  // one sample per call; calls back to back keep the strobe high
  task automatic send(input logic [13:0] b, input logic [13:0] t);
    @(posedge clock);
    sample_valid <= 1'b1;
    raw_bridge_result <= b;
    internal_temp_sense_raw <= t;
    last = model(b, t);
    expq.push_back(last);
  endtask : send

  // drop the strobe and let the pipeline drain
  task automatic idle;
    @(posedge clock);
    sample_valid <= 1'b0;
    repeat (6) @(posedge clock);
  endtask : idle

  // result timing and values; results pair bridge and temperature of one sample
  always @(posedge clock) begin
    if (reset) begin
      hist <= 4'h0;
    end else begin
      hist <= {hist[2:0], sample_valid};
      // a strobe taken four edges back is the oldest entry before this edge shifts it
      chk(out_valid, hist[3]);
      if (out_valid === 1'b1) begin
        if (expq.size() == 0) chk(1'b1, 1'b0);
        else chk({bridge_out, temp_out}, expq.pop_front());
      end
    end
  end

  // watchdog: far beyond the few thousand cycles the sequence needs
  initial begin
    #(20000 * 5);
    fails++;
    print_verdict();
  end

  // main sequence
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    addr = 4'h0;
    write_data = 16'h0000;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    sample_valid = 1'b0;
    raw_bridge_result = 14'h0000;
    internal_temp_sense_raw = 14'h0000;
    fails = 0;
    n_checks = 0;
    last = 28'h000_0000;
    for (int i = 0; i < 10; i++) sh[i] = 16'h0000;
    sh[0] = 16'h0800;
    sh[2] = 16'h0080;
    sh[8] = 16'h0001;
    void'($urandom(32'hb3d03e0a));
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    // values after reset, unmapped places read zero
    for (int i = 0; i < 16; i++) rd(4'(i), (i < 10) ? sh[i] : 16'h0000, (i == 12) ? 16'h0001 : 16'hffff);
    send(14'h3fff, 14'h3fff);
    send(14'h0000, 14'h0000);
    idle();
    // all ones: x8 gain, offset -1, prohibited selector; the bridge result register ignores writes
    for (int i = 0; i < 11; i++) wr(4'(i), 16'hffff);
    for (int i = 0; i < 10; i++) rd(4'(i), sh[i], 16'hffff);
    rd(4'hc, 16'h0001, 16'h0001);
    chk(sel_fault, 1'b1);
    send(14'h3fff, 14'h3fff);
    send(14'h0000, 14'h0000);
    send(14'h1234, 14'h2ffd);
    idle();
    rd(4'ha, {2'b00, last[27:14]}, 16'hffff);
    rd(4'hb, {2'b00, last[13:0]}, 16'hffff);
    // bridge offset of -4 pulls small readings to zero; temperature offset -128
    wr(4'h0, 16'h0800);
    wr(4'h1, 16'h7ffc);
    wr(4'h3, 16'h0080);
    wr(4'h4, 16'h0000);
    wr(4'h5, 16'h0000);
    send(14'h0000, 14'h0000);
    send(14'h0003, 14'h007f);
    send(14'h0064, 14'h3fff);
    idle();
    // every selector against every sign and scale setting
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 8; c++) begin
        wr(4'h8, 16'(s));
        wr(4'h6, 16'(c));
        for (int a = 4; a < 10; a++) if (a != 6 && a != 8) wr(4'(a), 16'($urandom));
        send(14'($urandom), 14'($urandom));
        send(14'h3fff, 14'h0000);
        idle();
        chk(sel_fault, s == 3);
      end
    end
    // zero gains and drifts leave only the offsets: both results clamp low
    wr(4'h0, 16'h0000);
    wr(4'h2, 16'h0000);
    wr(4'h4, 16'h0000);
    wr(4'h5, 16'h0000);
    send(14'h2a5a, 14'h1ff0);
    idle();
    rd(4'hc, {13'h0000, 2'b11, sh[8][1:0] == 2'h3}, 16'hffff);
    // fully random coefficient sets with bursts of samples
    repeat (40) begin
      for (int a = 0; a < 10; a++) wr(4'(a), 16'($urandom));
      repeat (5) send(14'($urandom), 14'($urandom));
      idle();
      chk(sel_fault, sh[8][1:0] == 2'h3);
    end
    chk(expq.size(), 28'h000_0000);
    print_verdict();
  end
endmodule : tb
